// *** core/bor_seq_defs.svh ***
// Notes on behaviour
// [RULE1] Supply dip drives a whole-device reset pulse
// [RULE2] Clock source follows select and mode fields
// [RULE3] Oscillator mode runs start-up timer, clock held
// [RULE4] With PLL, clock held until lock reads one
// [RULE5] Power-up delay runs alongside clock start-up
// [RULE6] Zero delay plus crystal uses fail-safe delay
// [RULE7] Dip flag in reset cause register bit 1
// [RULE8] Detection stays live in sleep and idle
// [RULE9] Dip flag cleared by zero write or power-on
`ifndef DIP_SEQ_DEFS_SVH
`define DIP_SEQ_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_PS 4000
`define RESET_PULSE_NS 40
`define RESET_PULSE_CYC ((`RESET_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OSC_STARTUP_CYC 1024
`define POWER_UP_DELAY_US 64
`define FAILSAFE_DELAY_US 2
`define POWER_UP_DELAY_CYC ((`POWER_UP_DELAY_US * 1000000) / `CLK_PERIOD_PS)
`define FAILSAFE_DELAY_CYC ((`FAILSAFE_DELAY_US * 1000000) / `CLK_PERIOD_PS)

// ****************************************
// Register map
// ****************************************
`define REG_RESET_CAUSE 8'h00
`define REG_OSC_CONTROL 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_CLEAR 8'h0C
`define REG_INT_ENABLE 8'h10

// ****************************************
// Fields
// ****************************************
`define CAUSE_DIP_BIT 1
`define CAUSE_DIP_LOW_POWER_BIT 3
`define OSC_LOCK_BIT 5
`define INT_DIP_BIT 0
`define INT_RELEASE_BIT 1
`define INT_WIDTH 2

// ****************************************
// Configuration encodings
// ****************************************
`define SEL_FRC_PLL 3'h1
`define SEL_PRIMARY 3'h2
`define SEL_PRIMARY_PLL 3'h3
`define MODE_XT 2'h1
`define MODE_HS 2'h2

`endif

// *** core/bor_seq_pkg.sv ***
package dip_seq_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PULSE,
        ST_WAIT
    } seq_state_e;

    typedef logic [15:0] reg_data_t;

endpackage : dip_seq_pkg

// *** core/brown_out_reset_sequencer.sv ***
`timescale 1ns/100ps
`include "bor_seq_defs.svh"

module brown_out_reset_sequencer #(
    parameter int POWER_UP_CYC = `POWER_UP_DELAY_CYC,
    parameter int FAILSAFE_CYC = `FAILSAFE_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic supply_low,
    input wire logic pll_locked,
    input wire logic low_power_mode,
    input wire logic [2:0] osc_select_cfg,
    input wire logic [1:0] primary_osc_mode_cfg,
    input wire logic power_up_timer_en,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    output logic device_reset_b,
    output logic sys_clk_en,
    output logic [2:0] clk_source_sel,
    output logic osc_startup_en,
    output logic irq
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [8:0] sync_a;
    logic [8:0] sync_b;
    logic [8:0] next_sync_a;
    logic [8:0] next_sync_b;

    always_comb
    begin
        next_sync_a = {power_up_timer_en, primary_osc_mode_cfg, osc_select_cfg,
                       low_power_mode, pll_locked, supply_low};
        next_sync_b = sync_a;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_a <= 9'h000;
            sync_b <= 9'h000;
        end
        else
        begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    logic dip;
    logic locked;
    logic in_low_power;
    logic [2:0] sel;
    logic [1:0] mode;
    logic pu_timer_on;

    assign dip = sync_b[0];
    assign locked = sync_b[1];
    assign in_low_power = sync_b[2];
    assign sel = sync_b[5:3];
    assign mode = sync_b[7:6];
    assign pu_timer_on = sync_b[8];

    // ****************************************
    // Clock source decode
    // ****************************************
    logic primary_sel;
    logic crystal;
    logic pll_used;

    // [RULE2] Decode source fields
    always_comb
    begin
        primary_sel = (sel == `SEL_PRIMARY) || (sel == `SEL_PRIMARY_PLL);
        crystal = primary_sel && ((mode == `MODE_XT) || (mode == `MODE_HS));
        pll_used = (sel == `SEL_FRC_PLL) || (sel == `SEL_PRIMARY_PLL);
    end

    // ****************************************
    // Reset sequence
    // ****************************************
    dip_seq_pkg::seq_state_e state;
    dip_seq_pkg::seq_state_e next_state;
    logic [31:0] delay_cnt;
    logic [31:0] next_delay_cnt;
    logic [31:0] osc_timer_cnt;
    logic [31:0] next_osc_timer_cnt;
    logic [31:0] pulse_cnt;
    logic [31:0] next_pulse_cnt;
    logic next_device_reset_b;
    logic next_sys_clk_en;
    logic [2:0] next_clk_source_sel;
    logic next_osc_startup_en;
    logic ev_dip;
    logic ev_release;
    logic clock_ready;

    always_comb
    begin
        next_state = state;
        next_delay_cnt = delay_cnt;
        next_osc_timer_cnt = osc_timer_cnt;
        next_pulse_cnt = pulse_cnt;
        next_device_reset_b = device_reset_b;
        next_sys_clk_en = sys_clk_en;
        next_clk_source_sel = clk_source_sel;
        next_osc_startup_en = osc_startup_en;
        ev_dip = 1'b0;
        ev_release = 1'b0;
        clock_ready = 1'b0;
        // [RULE8] Dip seen in any power mode
        if (dip && (state != dip_seq_pkg::ST_PULSE))
        begin
            // [RULE1] Enter reset pulse
            next_state = dip_seq_pkg::ST_PULSE;
            next_device_reset_b = 1'b0;
            next_sys_clk_en = 1'b0;
            next_osc_startup_en = 1'b0;
            next_pulse_cnt = 32'(`RESET_PULSE_CYC);
            ev_dip = 1'b1;
        end
        else
        begin
            unique case (state)
                dip_seq_pkg::ST_RUN:
                begin
                    next_device_reset_b = 1'b1;
                end
                dip_seq_pkg::ST_PULSE:
                begin
                    if (dip)
                    begin
                        next_pulse_cnt = 32'(`RESET_PULSE_CYC);
                    end
                    else if (pulse_cnt > 32'h1)
                    begin
                        next_pulse_cnt = pulse_cnt - 32'h1;
                    end
                    else
                    begin
                        next_state = dip_seq_pkg::ST_WAIT;
                        // [RULE2] Latch chosen source
                        next_clk_source_sel = sel;
                        // [RULE3] Start oscillator timer
                        next_osc_startup_en = crystal;
                        next_osc_timer_cnt = crystal ? 32'(`OSC_STARTUP_CYC) : 32'h0;
                        // [RULE6] Fail-safe delay choice
                        if (!pu_timer_on && crystal)
                        begin
                            next_delay_cnt = 32'(FAILSAFE_CYC);
                        end
                        // [RULE5] Power-up delay load
                        else if (pu_timer_on)
                        begin
                            next_delay_cnt = 32'(POWER_UP_CYC);
                        end
                        else
                        begin
                            next_delay_cnt = 32'h0;
                        end
                    end
                end
                dip_seq_pkg::ST_WAIT:
                begin
                    if (osc_timer_cnt != 32'h0)
                    begin
                        next_osc_timer_cnt = osc_timer_cnt - 32'h1;
                    end
                    if (delay_cnt != 32'h0)
                    begin
                        next_delay_cnt = delay_cnt - 32'h1;
                    end
                    // [RULE3] Hold clock for timer
                    // [RULE4] Hold clock for lock
                    clock_ready = (osc_timer_cnt == 32'h0) && (!pll_used || locked);
                    if (clock_ready)
                    begin
                        next_sys_clk_en = 1'b1;
                        next_osc_startup_en = 1'b0;
                    end
                    // [RULE5] Release after delay
                    if (clock_ready && (delay_cnt == 32'h0))
                    begin
                        next_state = dip_seq_pkg::ST_RUN;
                        next_device_reset_b = 1'b1;
                        ev_release = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= dip_seq_pkg::ST_RUN;
            delay_cnt <= 32'h0;
            osc_timer_cnt <= 32'h0;
            pulse_cnt <= 32'h0;
            device_reset_b <= 1'b1;
            sys_clk_en <= 1'b1;
            clk_source_sel <= 3'h0;
            osc_startup_en <= 1'b0;
        end
        else
        begin
            state <= next_state;
            delay_cnt <= next_delay_cnt;
            osc_timer_cnt <= next_osc_timer_cnt;
            pulse_cnt <= next_pulse_cnt;
            device_reset_b <= next_device_reset_b;
            sys_clk_en <= next_sys_clk_en;
            clk_source_sel <= next_clk_source_sel;
            osc_startup_en <= next_osc_startup_en;
        end
    end

    // ****************************************
    // Registers and interrupt
    // ****************************************
    logic cause_dip;
    logic cause_dip_low_power;
    logic [`INT_WIDTH-1:0] int_status;
    logic [`INT_WIDTH-1:0] int_enable;
    logic next_cause_dip;
    logic next_cause_dip_low_power;
    logic [`INT_WIDTH-1:0] next_int_status;
    logic [`INT_WIDTH-1:0] next_int_enable;
    logic [`INT_WIDTH-1:0] int_events;
    logic [15:0] next_rd_data;
    logic next_irq;

    always_comb
    begin
        next_cause_dip = cause_dip;
        next_cause_dip_low_power = cause_dip_low_power;
        next_int_status = int_status;
        next_int_enable = int_enable;
        next_rd_data = 16'h0000;
        int_events = '0;
        int_events[`INT_DIP_BIT] = ev_dip;
        int_events[`INT_RELEASE_BIT] = ev_release;
        if (wr_en)
        begin
            unique case (addr)
                `REG_RESET_CAUSE:
                begin
                    // [RULE9] Cleared by zero write
                    if (!wr_data[`CAUSE_DIP_BIT])
                    begin
                        next_cause_dip = 1'b0;
                    end
                    if (!wr_data[`CAUSE_DIP_LOW_POWER_BIT])
                    begin
                        next_cause_dip_low_power = 1'b0;
                    end
                end
                `REG_INT_CLEAR:
                begin
                    next_int_status = int_status & ~wr_data[`INT_WIDTH-1:0];
                end
                `REG_INT_ENABLE:
                begin
                    next_int_enable = wr_data[`INT_WIDTH-1:0];
                end
                default:
                begin
                end
            endcase
        end
        // [RULE7] Set flag, set beats clear
        if (ev_dip)
        begin
            next_cause_dip = 1'b1;
            next_cause_dip_low_power = in_low_power;
        end
        next_int_status = next_int_status | int_events;
        if (rd_en)
        begin
            unique case (addr)
                `REG_RESET_CAUSE:
                begin
                    next_rd_data[`CAUSE_DIP_BIT] = cause_dip;
                    next_rd_data[`CAUSE_DIP_LOW_POWER_BIT] = cause_dip_low_power;
                end
                `REG_OSC_CONTROL:
                begin
                    next_rd_data[`OSC_LOCK_BIT] = locked;
                    next_rd_data[2:0] = clk_source_sel;
                end
                `REG_INT_STATUS:
                begin
                    next_rd_data[`INT_WIDTH-1:0] = int_status;
                end
                `REG_INT_ENABLE:
                begin
                    next_rd_data[`INT_WIDTH-1:0] = int_enable;
                end
                default:
                begin
                end
            endcase
        end
        next_irq = |(next_int_status & next_int_enable);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cause_dip <= 1'b0;
            cause_dip_low_power <= 1'b0;
            int_status <= '0;
            int_enable <= '0;
            rd_data <= 16'h0000;
            irq <= 1'b0;
        end
        else
        begin
            cause_dip <= next_cause_dip;
            cause_dip_low_power <= next_cause_dip_low_power;
            int_status <= next_int_status;
            int_enable <= next_int_enable;
            rd_data <= next_rd_data;
            irq <= next_irq;
        end
    end

endmodule : brown_out_reset_sequencer

// *** verification/supply_osc_model.sv ***
`timescale 1ns/100ps
module supply_osc_model #(
    parameter int DIP_LEN = 4,
    parameter int LOCK_DELAY = 60
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic dip_start,
    output logic supply_low,
    output logic pll_locked
);
    // ****************************************
    // Supply and lock behaviour
    // ****************************************
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;
    logic [7:0] lock_cnt;
    logic [7:0] next_lock_cnt;
    always_comb
    begin
        next_low_cnt = (low_cnt != 8'h00) ? low_cnt - 8'h01 : 8'h00;
        if (dip_start)
            next_low_cnt = 8'(DIP_LEN);
        next_lock_cnt = (lock_cnt != 8'h00) ? lock_cnt - 8'h01 : 8'h00;
        if (next_low_cnt != 8'h00)
            next_lock_cnt = 8'(LOCK_DELAY);
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            low_cnt <= 8'h00;
            lock_cnt <= 8'h00;
        end
        else
        begin
            low_cnt <= next_low_cnt;
            lock_cnt <= next_lock_cnt;
        end
    end
    assign supply_low = (low_cnt != 8'h00);
    assign pll_locked = (lock_cnt == 8'h00);
endmodule : supply_osc_model

// *** verification/bor_seq_checker.sv ***
`timescale 1ns/100ps
`include "bor_seq_defs.svh"
module dip_seq_checker #(
    parameter int POWER_UP_CYC = 20,
    parameter int FAILSAFE_CYC = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic supply_low,
    input wire logic pll_locked,
    input wire logic low_power_mode,
    input wire logic rd_en,
    input wire logic [15:0] rd_data,
    input wire logic device_reset_b,
    input wire logic sys_clk_en,
    input wire logic [2:0] clk_source_sel,
    input wire logic osc_startup_en
);
    // ****************************************
    // Sequencing properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic pll_sel;
    assign pll_sel = (clk_source_sel == `SEL_FRC_PLL) || (clk_source_sel == `SEL_PRIMARY_PLL);
    dip_reset_a: assert property ($rose(supply_low) |-> ##[1:4] !device_reset_b)
        else $error("no reset after supply dip");
    sleep_dip_a: assert property ($rose(supply_low) && low_power_mode |->
        ##[1:4] !device_reset_b)
        else $error("no reset after dip in low power");
    pulse_len_a: assert property ($fell(device_reset_b) |->
        (!device_reset_b && !sys_clk_en) [*8])
        else $error("reset pulse too short");
    release_clk_a: assert property ($rose(device_reset_b) |-> sys_clk_en)
        else $error("reset released before clock ready");
    source_hold_a: assert property (device_reset_b && $past(device_reset_b) |->
        $stable(clk_source_sel))
        else $error("clock source changed while running");
    pll_hold_a: assert property ($rose(sys_clk_en) && pll_sel |->
        $past(pll_locked, 2) || $past(pll_locked, 3) || $past(pll_locked, 4))
        else $error("clock released without lock");
    start_hold_a: assert property ($rose(osc_startup_en) |->
        (osc_startup_en && !sys_clk_en) [*8])
        else $error("clock released during start-up timer");
    rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
        else $error("read data outside answer cycle");
endmodule : dip_seq_checker
bind brown_out_reset_sequencer dip_seq_checker #(.POWER_UP_CYC(POWER_UP_CYC),
    .FAILSAFE_CYC(FAILSAFE_CYC)) chk (.clk(clk), .rst_b(rst_b), .supply_low(supply_low),
    .pll_locked(pll_locked), .low_power_mode(low_power_mode), .rd_en(rd_en), .rd_data(rd_data),
    .device_reset_b(device_reset_b), .sys_clk_en(sys_clk_en), .clk_source_sel(clk_source_sel),
    .osc_startup_en(osc_startup_en));

// *** verification/brown_out_reset_sequencer_tb_top.sv ***
`timescale 1ns/100ps
`include "bor_seq_defs.svh"
`define CHK(a, b) \
    begin \
        checks++; \
        if ((a) !== (b)) \
        begin \
            fails++; \
            $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module brown_out_reset_sequencer_tb_top;
    // ****************************************
    // Bench signals and tasks
    // ****************************************
    localparam int PU = 20;
    // Fail-safe delay set above the start-up timer so that it is visible
    localparam int FS = 1100;
    logic clk, rst_b, dip_start, supply_low, pll_locked, low_power_mode, power_up_timer_en;
    logic [2:0] osc_select_cfg, clk_source_sel;
    logic [1:0] primary_osc_mode_cfg;
    logic [7:0] addr;
    logic [15:0] wr_data, rd_data;
    logic wr_en, rd_en, device_reset_b, sys_clk_en, osc_startup_en, irq, saw_timer, lock_at_clk;
    int checks, fails, t_clk, t_rst;
    supply_osc_model model (.clk(clk), .rst_b(rst_b), .dip_start(dip_start),
        .supply_low(supply_low), .pll_locked(pll_locked));
    brown_out_reset_sequencer #(.POWER_UP_CYC(PU), .FAILSAFE_CYC(FS)) DUT (.clk(clk),
        .rst_b(rst_b), .supply_low(supply_low), .pll_locked(pll_locked),
        .low_power_mode(low_power_mode), .osc_select_cfg(osc_select_cfg),
        .primary_osc_mode_cfg(primary_osc_mode_cfg), .power_up_timer_en(power_up_timer_en),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .device_reset_b(device_reset_b), .sys_clk_en(sys_clk_en),
        .clk_source_sel(clk_source_sel), .osc_startup_en(osc_startup_en), .irq(irq));
    task finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : bus_wr
    task bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : bus_rd
    // Cycle counts are taken from the dip request
    task run_dip(input logic [2:0] sel, input logic [1:0] mode, input logic pu);
        logic seen;
        @(posedge clk);
        osc_select_cfg <= sel;
        primary_osc_mode_cfg <= mode;
        power_up_timer_en <= pu;
        repeat (4) @(posedge clk);
        dip_start <= 1'b1;
        @(posedge clk);
        dip_start <= 1'b0;
        {t_clk, t_rst, seen, saw_timer, lock_at_clk} = '0;
        for (int n = 1; n < 3000 && t_rst == 0; n++)
        begin
            @(posedge clk);
            #1;
            seen = seen | (device_reset_b === 1'b0);
            saw_timer = saw_timer | (osc_startup_en === 1'b1);
            if (seen && sys_clk_en === 1'b1 && t_clk == 0)
            begin
                t_clk = n;
                lock_at_clk = pll_locked;
            end
            if (seen && device_reset_b === 1'b1)
                t_rst = n;
        end
        if (t_rst == 0)
        begin
            fails++;
            finish_test;
        end
    endtask : run_dip
    // ****************************************
    // Scenarios
    // ****************************************
    task test_timing;
        logic [2:0] s [4] = '{`SEL_PRIMARY, `SEL_PRIMARY, 3'h0, `SEL_PRIMARY};
        logic [1:0] m [4] = '{`MODE_HS, `MODE_XT, 2'h0, 2'h3};
        logic p [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        int lo [4] = '{0, FS - `OSC_STARTUP_CYC - 1, PU - 1, 0};
        int hi [4] = '{1, FS - `OSC_STARTUP_CYC + 1, PU + 1, 1};
        for (int i = 0; i < 4; i++)
        begin
            run_dip(s[i], m[i], p[i]);
            `CHK(clk_source_sel, s[i])
            `CHK(saw_timer, i < 2)
            `CHK((i < 2) ? t_clk >= `OSC_STARTUP_CYC : t_clk <= 30, 1'b1)
            `CHK(t_rst - t_clk >= lo[i] && t_rst - t_clk <= hi[i], 1'b1)
        end
    endtask : test_timing
    task test_pll;
        logic [15:0] d;
        run_dip(`SEL_FRC_PLL, 2'h0, 1'b1);
        `CHK(lock_at_clk, 1'b1)
        `CHK(t_clk > 60, 1'b1)
        bus_rd(`REG_OSC_CONTROL, d);
        `CHK(d, 16'h0021)
        run_dip(`SEL_PRIMARY_PLL, `MODE_HS, 1'b0);
        `CHK(clk_source_sel, `SEL_PRIMARY_PLL)
        `CHK(saw_timer && lock_at_clk && t_clk >= `OSC_STARTUP_CYC, 1'b1)
        `CHK(t_rst - t_clk, FS - `OSC_STARTUP_CYC)
        bus_rd(`REG_OSC_CONTROL, d);
        `CHK(d, 16'h0023)
    endtask : test_pll
    task test_cause;
        logic [15:0] d;
        bus_rd(`REG_RESET_CAUSE, d);
        `CHK(d, 16'h0002)
        bus_wr(`REG_RESET_CAUSE, 16'h0000);
        bus_rd(`REG_RESET_CAUSE, d);
        `CHK(d, 16'h0000)
        bus_wr(`REG_RESET_CAUSE, 16'h000A);
        bus_rd(`REG_RESET_CAUSE, d);
        `CHK(d, 16'h0000)
        @(posedge clk);
        low_power_mode <= 1'b1;
        run_dip(3'h0, 2'h0, 1'b0);
        @(posedge clk);
        low_power_mode <= 1'b0;
        bus_rd(`REG_RESET_CAUSE, d);
        `CHK(d, 16'h000A)
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        bus_rd(`REG_RESET_CAUSE, d);
        `CHK(d, 16'h0000)
    endtask : test_cause
    task test_irq;
        logic [15:0] d;
        run_dip(3'h0, 2'h0, 1'b0);
        bus_wr(`REG_INT_ENABLE, 16'h0003);
        bus_rd(`REG_INT_ENABLE, d);
        `CHK(d, 16'h0003)
        bus_rd(`REG_INT_STATUS, d);
        `CHK(d, 16'h0003)
        `CHK(irq, 1'b1)
        bus_wr(`REG_INT_CLEAR, 16'h0001);
        bus_rd(`REG_INT_STATUS, d);
        `CHK(d, 16'h0002)
        bus_wr(`REG_INT_ENABLE, 16'h0001);
        bus_rd(`REG_INT_CLEAR, d);
        `CHK(d, 16'h0000)
        `CHK(irq, 1'b0)
        bus_wr(`REG_INT_CLEAR, 16'h0002);
        bus_rd(8'h20, d);
        `CHK(d, 16'h0000)
        bus_rd(`REG_INT_STATUS, d);
        `CHK(d, 16'h0000)
    endtask : test_irq
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        finish_test;
    end
    initial
    begin
        {rst_b, dip_start, low_power_mode, power_up_timer_en, wr_en, rd_en} = '0;
        {osc_select_cfg, primary_osc_mode_cfg, addr, wr_data} = '0;
        {checks, fails} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        test_timing;
        test_pll;
        test_cause;
        test_irq;
        finish_test;
    end
endmodule : brown_out_reset_sequencer_tb_top
